/* File: common/cmpm_regs.svh */
`ifndef CMPM_REGS_SVH
`define CMPM_REGS_SVH
`define CMPM_CLK_HZ 20000000
`define CMPM_SETTLE_US 100
`define CMPM_SETTLE_CYC ((`CMPM_CLK_HZ / 1000000) * `CMPM_SETTLE_US)
`define CMPM_CELLS 12
`define CMPM_MAX_DEV 14
`define CMPM_MAX_CELLS 168
`define CMPM_FILT_LEN 4
`define CMPM_FLT_CMD_CODE 8'he1
`define CMPM_FLT_SIG_CODE 8'he2
`endif

/* File: common/cmpm_pkg.sv */
package cmpm_pkg;
    typedef enum logic [2:0] {
        CMPM_SHUTDOWN = 3'b000,
        CMPM_SETTLE = 3'b001,
        CMPM_STANDBY = 3'b011,
        CMPM_ACTIVE = 3'b010,
        CMPM_SLEEP = 3'b110,
        CMPM_RECALL = 3'b111
    } cmpm_state_t;
    typedef enum logic [2:0] {
        CMPM_OP_NONE = 3'h0,
        CMPM_OP_SCAN_A = 3'h1,
        CMPM_OP_SCAN_B = 3'h2,
        CMPM_OP_DIRECT = 3'h3,
        CMPM_OP_OPENWIRE = 3'h4
    } cmpm_op_t;
    typedef enum logic [1:0] {
        CMPM_BAL_MANUAL = 2'h0,
        CMPM_BAL_TIMED = 2'h1,
        CMPM_BAL_AUTO = 2'h2
    } cmpm_bal_t;
endpackage

/* File: common/cmpm_flt_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface cmpm_flt_if;
    logic raw;
    logic filt;
    modport src (output raw, input filt);
    modport flt (input raw, output filt);
endinterface
`default_nettype wire

/* File: hdl/cmpm_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module cmpm_sync (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic d,
    output logic q
);
    logic s1_r;
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            s1_r <= 1'b0;
            q <= 1'b0;
        end else begin
            s1_r <= d;
            q <= s1_r;
        end
    end
endmodule
`default_nettype wire

/* File: hdl/cmpm_filter.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cmpm_regs.svh"
module cmpm_filter #(
    parameter int LEN = `CMPM_FILT_LEN
) (
    input wire logic clk_sys,
    input wire logic resetn,
    cmpm_flt_if.flt f
);
    // Fault input must hold steady LEN+1 cycles before it is believed
    logic [LEN-1:0] hist_r;
    logic filt_r;
    wire all_one = &{hist_r, f.raw};
    wire all_zero = ~|{hist_r, f.raw};
    assign f.filt = filt_r;
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            hist_r <= '0;
            filt_r <= 1'b0;
        end else begin
            hist_r <= {hist_r[LEN-2:0], f.raw};
            if (all_one) begin
                filt_r <= 1'b1;
            end else if (all_zero) begin
                filt_r <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: hdl/cmpm_power_seq.sv */
// Functional notes
// [R01] Sleep on sleep command or watchdog timeout; code ignores the sleep command while active
// [R02] Sleep keeps receivers, slow clock, registers, timed work
// [R03] Enable low forces shutdown unconditionally
// [R04] Shutdown keeps core, sleep regulators, input buffers
// [R05] Leaving shutdown skips nonvolatile recall
// [R06] Host toggles enable low then high
// [R07] Host waits settle delay, then identifies
// [R08] Reset command recalls settings, computes checksum
// [R09] Host re-identifies after every software reset
// [R10] Host compares stored and computed signatures
// [R11] Host rewrites non-default settings after reset
// [R12] Register checksum mismatch returns fault response
// [R13] Standby awaits commands; active during operations
// [R14] Twelve cells per device, fourteen devices
// [R15] Two scan modes plus direct measurement
// [R16] No result filtering; fault inputs filtered
// [R17] Faults in registers, responses, unprompted messages
// [R18] Manual, timed and auto-terminate balancing
// [R19] Wake from sleep returns to standby
`timescale 1ns/100ps
`default_nettype none
`include "cmpm_regs.svh"
module cmpm_power_seq
    import cmpm_pkg::*;
#(
    parameter int SETTLE_CYC = `CMPM_SETTLE_CYC,
    parameter int CELLS = `CMPM_CELLS, // R14
    parameter int DEV_ADDR_W = 4,
    parameter int CHARGE_W = 16
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic enable_pin,
    input wire logic comm_activity,
    input wire logic wdog_timeout,
    input wire logic cmd_valid,
    input wire logic cmd_sleep,
    input wire logic cmd_reset,
    input wire logic cmd_identify,
    input wire logic cmd_calc_chk,
    input wire logic cmd_check_chk,
    input wire logic cmd_start_op,
    input wire cmpm_pkg::cmpm_op_t cmd_op,
    input wire cmpm_pkg::cmpm_bal_t bal_mode,
    input wire logic [CELLS-1:0] bal_cells,
    input wire logic bal_timer_done,
    input wire logic [CHARGE_W-1:0] bal_charge_target,
    input wire logic [CHARGE_W-1:0] bal_charge_acc,
    input wire logic op_done,
    input wire logic recall_done,
    input wire logic [15:0] signature_compare_value,
    input wire logic [15:0] signature_calc_value,
    input wire logic [15:0] reg_chk_stored,
    input wire logic [15:0] reg_chk_calc,
    input wire logic fault_raw,
    input wire logic comm_fault,
    output logic [2:0] power_state,
    output logic bias_main_en,
    output logic fast_osc_en,
    output logic slow_osc_en,
    output logic rx_en,
    output logic core_en,
    output logic sleep_reg_en,
    output logic in_buf_en,
    output logic identified,
    output logic recall_start,
    output logic op_busy,
    output cmpm_pkg::cmpm_op_t op_running,
    output logic [CELLS-1:0] bal_drive,
    output logic chk_fault_resp,
    output logic [7:0] unprompted_code,
    output logic unprompted_valid,
    output logic fault_status,
    output logic sig_mismatch
);
    import cmpm_pkg::*;

    ////////////////////////////////////////////////////////////////
    // Input synchronisation
    logic en_s, act_s, flt_s;
    cmpm_sync u_sync_en (.clk_sys(clk_sys), .resetn(resetn), .d(enable_pin), .q(en_s));
    cmpm_sync u_sync_act (.clk_sys(clk_sys), .resetn(resetn), .d(comm_activity), .q(act_s));
    cmpm_sync u_sync_flt (.clk_sys(clk_sys), .resetn(resetn), .d(fault_raw), .q(flt_s));

    cmpm_flt_if flt_bus ();
    assign flt_bus.raw = flt_s;
    cmpm_filter u_filt (.clk_sys(clk_sys), .resetn(resetn), .f(flt_bus.flt)); // R16

    ////////////////////////////////////////////////////////////////
    // State machine
    cmpm_state_t state_r, state_nxt;
    logic [$clog2(SETTLE_CYC+1)-1:0] settle_r;
    cmpm_op_t op_r;
    logic ident_r;

    wire settle_done = (settle_r == '0);
    wire cmd_go = cmd_valid;
    wire go_sleep = (cmd_go && cmd_sleep) || wdog_timeout; // R01
    wire sig_bad = (signature_compare_value != signature_calc_value);
    wire reg_bad = (reg_chk_stored != reg_chk_calc);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            CMPM_SHUTDOWN: begin
                // No recall on exit from shutdown
                if (en_s) begin
                    state_nxt = CMPM_SETTLE; // R05
                end
            end
            CMPM_SETTLE: begin
                if (settle_done) begin
                    state_nxt = CMPM_STANDBY;
                end
            end
            CMPM_STANDBY: begin
                if (go_sleep) begin
                    state_nxt = CMPM_SLEEP; // R01
                end else if (cmd_go && cmd_reset) begin
                    state_nxt = CMPM_RECALL; // R08
                end else if (cmd_go && cmd_start_op && cmd_op != CMPM_OP_NONE) begin
                    state_nxt = CMPM_ACTIVE; // R13
                end
            end
            CMPM_ACTIVE: begin
                if (wdog_timeout) begin
                    state_nxt = CMPM_SLEEP; // R01
                end else if (op_done) begin
                    state_nxt = CMPM_STANDBY; // R13
                end
            end
            CMPM_SLEEP: begin
                if (act_s) begin
                    state_nxt = CMPM_STANDBY; // R19
                end
            end
            CMPM_RECALL: begin
                if (recall_done) begin
                    state_nxt = CMPM_STANDBY; // R08
                end
            end
            default: state_nxt = CMPM_SHUTDOWN;
        endcase
        if (!en_s) begin
            state_nxt = CMPM_SHUTDOWN; // R03
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_r <= CMPM_SHUTDOWN;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        // Count restarts on every entry to settle
        if (!resetn || state_r != CMPM_SETTLE) begin
            settle_r <= ($clog2(SETTLE_CYC+1))'(SETTLE_CYC - 1);
        end else if (!settle_done) begin
            settle_r <= settle_r - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Operation and identify tracking
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            op_r <= CMPM_OP_NONE;
        end else if (state_r == CMPM_STANDBY && state_nxt == CMPM_ACTIVE) begin
            op_r <= cmd_op; // R15
        end else if (state_nxt != CMPM_ACTIVE) begin
            op_r <= CMPM_OP_NONE;
        end
    end

    // Busy flag registered so the output comes straight from a flop
    logic busy_r;
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= (state_nxt == CMPM_ACTIVE); // R13
        end
    end

    // Identity is lost by hardware and software reset alike
    always_ff @(posedge clk_sys) begin
        if (!resetn || state_r == CMPM_SHUTDOWN || state_r == CMPM_RECALL) begin
            ident_r <= 1'b0; // R09
        end else if (cmd_go && cmd_identify && state_r == CMPM_STANDBY) begin
            ident_r <= 1'b1; // R07
        end
    end

    ////////////////////////////////////////////////////////////////
    // Balancing
    logic bal_on;
    assign bal_on = (bal_mode == CMPM_BAL_MANUAL) ? 1'b1 :
                    (bal_mode == CMPM_BAL_TIMED) ? !bal_timer_done :
                    (bal_charge_acc < bal_charge_target); // R18
    wire bal_allowed = (state_r == CMPM_STANDBY || state_r == CMPM_ACTIVE || state_r == CMPM_SLEEP); // R02
    logic [CELLS-1:0] bal_r;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            bal_r <= '0;
        end else begin
            bal_r <= (bal_allowed && bal_on) ? bal_cells : '0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Fault reporting
    logic chk_r, uv_r, fs_r, sm_r, rs_r;
    logic [7:0] uc_r;
    wire recall_exit = (state_r == CMPM_RECALL) && recall_done;
    wire comm_flt_rep = comm_fault && (state_r != CMPM_SHUTDOWN);
    wire sig_flt_rep = recall_exit && sig_bad;
    wire chk_req = cmd_go && cmd_check_chk && (state_r == CMPM_STANDBY);

    // Checksum fault response pulse
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            chk_r <= 1'b0;
        end else begin
            chk_r <= chk_req && reg_bad; // R12
        end
    end

    // Unprompted message; comm faults outrank the signature fault
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            uv_r <= 1'b0;
            uc_r <= 8'h00;
        end else begin
            uv_r <= comm_flt_rep || sig_flt_rep; // R17
            if (comm_flt_rep) begin
                uc_r <= `CMPM_FLT_CMD_CODE; // R17
            end else if (sig_flt_rep) begin
                uc_r <= `CMPM_FLT_SIG_CODE; // R17
            end
        end
    end

    // Filtered fault level, signature verdict, recall pulse
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            fs_r <= 1'b0;
            sm_r <= 1'b0;
            rs_r <= 1'b0;
        end else begin
            fs_r <= flt_bus.filt; // R16 R17
            if (recall_exit) begin
                sm_r <= sig_bad; // R10
            end
            rs_r <= (state_r == CMPM_STANDBY) && (state_nxt == CMPM_RECALL); // R08
        end
    end

    ////////////////////////////////////////////////////////////////
    // Power domain enables
    logic bias_r, fosc_r, sosc_r, rx_r;
    // Fast clock and main bias run only in the full-power states
    function automatic logic full_power(input cmpm_state_t s);
        return (s != CMPM_SHUTDOWN) && (s != CMPM_SLEEP);
    endfunction
    wire full_nxt = full_power(state_nxt);

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            bias_r <= 1'b0;
            fosc_r <= 1'b0;
            sosc_r <= 1'b1;
            rx_r <= 1'b0;
        end else begin
            bias_r <= full_nxt; // R04
            fosc_r <= full_nxt; // R02
            sosc_r <= 1'b1;
            rx_r <= state_nxt != CMPM_SHUTDOWN; // R02
        end
    end

    assign power_state = state_r;
    assign bias_main_en = bias_r;
    assign fast_osc_en = fosc_r;
    assign slow_osc_en = sosc_r;
    assign rx_en = rx_r;
    assign core_en = sosc_r; // R04
    assign sleep_reg_en = sosc_r; // R04
    assign in_buf_en = sosc_r; // R04
    assign identified = ident_r;
    assign recall_start = rs_r;
    assign op_busy = busy_r;
    assign op_running = op_r;
    assign bal_drive = bal_r;
    assign chk_fault_resp = chk_r;
    assign unprompted_code = uc_r;
    assign unprompted_valid = uv_r;
    assign fault_status = fs_r;
    assign sig_mismatch = sm_r;
endmodule
`default_nettype wire

/* File: tb/cmpm_power_seq_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module cmpm_power_seq_checker
    import cmpm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic enable_pin,
    input wire logic comm_activity,
    input wire logic wdog_timeout,
    input wire logic cmd_valid,
    input wire logic cmd_sleep,
    input wire logic cmd_reset,
    input wire logic cmd_start_op,
    input wire cmpm_pkg::cmpm_op_t cmd_op,
    input wire logic fault_raw,
    input wire logic [2:0] power_state,
    input wire logic bias_main_en,
    input wire logic fast_osc_en,
    input wire logic rx_en,
    input wire logic core_en,
    input wire logic recall_start,
    input wire logic op_busy,
    input wire cmpm_pkg::cmpm_op_t op_running,
    input wire logic fault_status
);
    import cmpm_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // Standby with a command accepted this edge
    wire go = power_state == CMPM_STANDBY && cmd_valid && enable_pin && !wdog_timeout;
    property p_off; !enable_pin [*3] |=> power_state == CMPM_SHUTDOWN; endproperty
    a_off: assert property (p_off) else $error("enable low without shutdown");
    property p_keep; power_state == CMPM_SHUTDOWN |-> core_en && !bias_main_en; endproperty
    a_keep: assert property (p_keep) else $error("shutdown supplies wrong");
    property p_norecall; power_state == CMPM_SETTLE |-> !recall_start; endproperty
    a_norecall: assert property (p_norecall) else $error("recall during power up");
    property p_slp; go && cmd_sleep |=> power_state == CMPM_SLEEP; endproperty
    a_slp: assert property (p_slp) else $error("sleep command ignored");
    property p_slpon; power_state == CMPM_SLEEP |-> rx_en && !fast_osc_en && !bias_main_en; endproperty
    a_slpon: assert property (p_slpon) else $error("sleep supplies wrong");
    property p_wake;
        power_state == CMPM_SLEEP && comm_activity && enable_pin |-> ##[1:4] power_state == CMPM_STANDBY;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on activity");
    property p_rst; go && cmd_reset && !cmd_sleep |=> power_state == CMPM_RECALL && recall_start; endproperty
    a_rst: assert property (p_rst) else $error("reset command without recall");
    property p_op;
        go && cmd_start_op && !cmd_sleep && !cmd_reset && cmd_op != CMPM_OP_NONE
            |=> op_busy && op_running == $past(cmd_op);
    endproperty
    a_op: assert property (p_op) else $error("operation not started");
    property p_flt; $rose(fault_status) |-> $past(fault_raw, 4) && $past(fault_raw, 6) && $past(fault_raw, 8); endproperty
    a_flt: assert property (p_flt) else $error("fault flag unfiltered");
endmodule
bind cmpm_power_seq cmpm_power_seq_checker i_cmpm_power_seq_checker (
    .clk_sys(clk_sys), .resetn(resetn), .enable_pin(enable_pin), .comm_activity(comm_activity),
    .wdog_timeout(wdog_timeout),
    .cmd_valid(cmd_valid), .cmd_sleep(cmd_sleep), .cmd_reset(cmd_reset), .cmd_start_op(cmd_start_op),
    .cmd_op(cmd_op), .fault_raw(fault_raw), .power_state(power_state), .bias_main_en(bias_main_en),
    .fast_osc_en(fast_osc_en), .rx_en(rx_en), .core_en(core_en), .recall_start(recall_start),
    .op_busy(op_busy), .op_running(op_running), .fault_status(fault_status)
);
`default_nettype wire

/* File: tb/cmpm_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module cmpm_host_model
    import cmpm_pkg::*;
#(
    parameter int SETTLE_CYC = 4
) (
    input wire logic clk_sys,
    output logic enable_pin,
    output logic cmd_valid,
    output logic [5:0] cmd_kind,
    output cmpm_pkg::cmpm_op_t cmd_op
);
    import cmpm_pkg::*;
    initial begin
        enable_pin = 1'b0;
        cmd_valid = 1'b0;
        cmd_kind = 6'h00;
        cmd_op = CMPM_OP_NONE;
    end
    // Kind bits: sleep, reset, identify, calc, check, start
    task automatic send(input logic [5:0] kind, input cmpm_op_t op);
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_kind = kind;
        cmd_op = op;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        cmd_kind = 6'h00;
        cmd_op = CMPM_OP_NONE;
    endtask
    task automatic set_enable(input logic lvl);
        @(negedge clk_sys);
        enable_pin = lvl;
    endtask
    // Settle, then identify before any other command
    task automatic hw_wake();
        set_enable(1'b1);
        repeat (SETTLE_CYC + 6) @(negedge clk_sys);
        send(6'h04, CMPM_OP_NONE);
    endtask
endmodule
`default_nettype wire

/* File: tb/cmpm_power_seq_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cmpm_regs.svh"
`define CMPM_CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module cmpm_power_seq_tb_top;
    import cmpm_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    int err_total = 0;
    int checked = 0;
    int rcnt = 0;
    int fcnt = 0;
    int ucnt = 0;
    int scnt = 0;
    logic comm_activity = 1'b0, wdog_timeout = 1'b0, op_done = 1'b0, recall_done = 1'b0;
    logic fault_raw = 1'b0, comm_fault = 1'b0, bal_timer_done = 1'b0;
    cmpm_bal_t bal_mode = CMPM_BAL_MANUAL;
    logic [11:0] bal_cells = 12'h000;
    logic [15:0] tgt = 16'h0010, acc = 16'h0000, sig_a = 16'h1234, sig_b = 16'h1234, chk_b = 16'h0000;
    wire enable_pin, cmd_valid;
    wire [5:0] cmd_kind;
    wire cmpm_op_t cmd_op, op_running;
    wire [2:0] power_state;
    wire [7:0] unprompted_code;
    wire [11:0] bal_drive;
    wire bias_main_en, fast_osc_en, slow_osc_en, rx_en, core_en, sleep_reg_en, in_buf_en, identified;
    wire recall_start, op_busy, chk_fault_resp, unprompted_valid, fault_status, sig_mismatch;
    initial forever #25 clk_sys = ~clk_sys;
    cmpm_host_model #(.SETTLE_CYC(4)) i_cmpm_host_model (.clk_sys(clk_sys), .enable_pin(enable_pin),
        .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_op(cmd_op));
    cmpm_power_seq #(.SETTLE_CYC(4)) i_cmpm_power_seq (.clk_sys(clk_sys), .resetn(resetn),
        .enable_pin(enable_pin), .comm_activity(comm_activity), .wdog_timeout(wdog_timeout),
        .cmd_valid(cmd_valid), .cmd_sleep(cmd_kind[0]), .cmd_reset(cmd_kind[1]), .cmd_identify(cmd_kind[2]),
        .cmd_calc_chk(cmd_kind[3]), .cmd_check_chk(cmd_kind[4]), .cmd_start_op(cmd_kind[5]), .cmd_op(cmd_op),
        .bal_mode(bal_mode), .bal_cells(bal_cells), .bal_timer_done(bal_timer_done), .bal_charge_target(tgt),
        .bal_charge_acc(acc), .op_done(op_done), .recall_done(recall_done), .signature_compare_value(sig_a),
        .signature_calc_value(sig_b), .reg_chk_stored(16'h0000), .reg_chk_calc(chk_b), .fault_raw(fault_raw),
        .comm_fault(comm_fault), .power_state(power_state), .bias_main_en(bias_main_en),
        .fast_osc_en(fast_osc_en), .slow_osc_en(slow_osc_en), .rx_en(rx_en), .core_en(core_en),
        .sleep_reg_en(sleep_reg_en), .in_buf_en(in_buf_en), .identified(identified),
        .recall_start(recall_start), .op_busy(op_busy), .op_running(op_running), .bal_drive(bal_drive),
        .chk_fault_resp(chk_fault_resp), .unprompted_code(unprompted_code),
        .unprompted_valid(unprompted_valid), .fault_status(fault_status), .sig_mismatch(sig_mismatch));
    always @(posedge clk_sys) begin
        if (recall_start === 1'b1) rcnt++;
        if (chk_fault_resp === 1'b1) fcnt++;
        if (unprompted_valid === 1'b1 && unprompted_code === `CMPM_FLT_CMD_CODE) ucnt++;
        if (unprompted_valid === 1'b1 && unprompted_code === `CMPM_FLT_SIG_CODE) scnt++;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk_sys);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
    endtask
    task automatic wait_st(input logic [2:0] s, input int n);
        for (int i = 0; i < n && power_state !== s; i++) @(negedge clk_sys);
        `CMPM_CHK(power_state, s)
    endtask
    task automatic wake();
        tick(1);
        comm_activity = 1'b1;
        wait_st(CMPM_STANDBY, 6);
        comm_activity = 1'b0;
    endtask
    task automatic t_up();
        `CMPM_CHK({core_en, sleep_reg_en, in_buf_en, slow_osc_en, bias_main_en}, 5'b11110)
        i_cmpm_host_model.hw_wake();
        `CMPM_CHK({power_state, bias_main_en, fast_osc_en, identified}, {CMPM_STANDBY, 3'b111})
        `CMPM_CHK(rcnt, 0)
        $display("t_up done");
    endtask
    task automatic t_sleep();
        i_cmpm_host_model.send(6'h01, CMPM_OP_NONE);
        wait_st(CMPM_SLEEP, 2);
        `CMPM_CHK({rx_en, slow_osc_en, fast_osc_en, bias_main_en}, 4'b1100)
        wake();
        pulse(wdog_timeout);
        wait_st(CMPM_SLEEP, 2);
        wake();
        $display("t_sleep done");
    endtask
    task automatic t_ops();
        cmpm_op_t ops [4];
        ops = '{CMPM_OP_SCAN_A, CMPM_OP_SCAN_B, CMPM_OP_DIRECT, CMPM_OP_OPENWIRE};
        foreach (ops[i]) begin
            i_cmpm_host_model.send(6'h20, ops[i]);
            wait_st(CMPM_ACTIVE, 2);
            `CMPM_CHK({op_busy, op_running}, {1'b1, ops[i]})
            i_cmpm_host_model.send(6'h01, CMPM_OP_NONE);
            `CMPM_CHK(power_state, CMPM_ACTIVE)
            pulse(op_done);
            wait_st(CMPM_STANDBY, 3);
        end
        $display("t_ops done");
    endtask
    task automatic t_recall();
        sig_b = 16'h1235;
        i_cmpm_host_model.send(6'h02, CMPM_OP_NONE);
        wait_st(CMPM_RECALL, 2);
        tick(1);
        `CMPM_CHK(rcnt, 1)
        pulse(recall_done);
        wait_st(CMPM_STANDBY, 3);
        `CMPM_CHK({sig_mismatch, identified}, 2'b10)
        i_cmpm_host_model.send(6'h04, CMPM_OP_NONE);
        `CMPM_CHK(identified, 1'b1)
        `CMPM_CHK(scnt, 1)
        for (int k = 0; k < 2; k++) begin
            chk_b = (k == 0) ? 16'h0001 : 16'h0000;
            i_cmpm_host_model.send(6'h08, CMPM_OP_NONE);
            i_cmpm_host_model.send(6'h10, CMPM_OP_NONE);
            tick(3);
            `CMPM_CHK(fcnt, 1)
        end
        $display("t_recall done");
    endtask
    task automatic t_flt();
        pulse(comm_fault);
        tick(4);
        `CMPM_CHK(ucnt, 1)
        pulse(fault_raw);
        tick(8);
        `CMPM_CHK(fault_status, 1'b0)
        fault_raw = 1'b1;
        tick(10);
        `CMPM_CHK(fault_status, 1'b1)
        fault_raw = 1'b0;
        bal_cells = 12'hfff;
        tick(2);
        `CMPM_CHK(bal_drive, 12'hfff)
        bal_mode = CMPM_BAL_TIMED;
        bal_timer_done = 1'b1;
        tick(2);
        `CMPM_CHK(bal_drive, 12'h000)
        bal_mode = CMPM_BAL_AUTO;
        acc = 16'h0000;
        tick(2);
        `CMPM_CHK(bal_drive, 12'hfff)
        acc = tgt;
        tick(4);
        `CMPM_CHK(bal_drive, 12'h000)
        $display("t_flt done");
    endtask
    task automatic t_off();
        i_cmpm_host_model.send(6'h20, CMPM_OP_SCAN_A);
        i_cmpm_host_model.set_enable(1'b0);
        i_cmpm_host_model.send(6'h01, CMPM_OP_NONE);
        wait_st(CMPM_SHUTDOWN, 5);
        `CMPM_CHK({core_en, sleep_reg_en, in_buf_en, bias_main_en}, 4'b1110)
        i_cmpm_host_model.hw_wake();
        `CMPM_CHK({power_state, rcnt}, {CMPM_STANDBY, 32'd1})
        $display("t_off done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        report_and_stop();
    end
    initial begin
        tick(12);
        resetn = 1'b1;
        t_up();
        t_sleep();
        t_ops();
        t_recall();
        t_flt();
        t_off();
        report_and_stop();
    end
endmodule
`default_nettype wire
